// File: rtl/bzc_zone_regs.sv
// bright and office zone maximum and dim current registers with code selection
`timescale 1ns/1ps
module bzc_zone_regs
  import bzc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrEn,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regRdEn,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [1:0]        zoneSel,
  input  wire logic              dimTimeout,
  input  wire logic              dimEnable,
  output logic      [CODE_W-1:0] currentCode,
  output logic                   dimActive,
  output logic                   zeroCurrent,
  output logic                   fullScale
);
  bzc_regs_type regQ;
  bzc_regs_type regD;
  logic [6:0]   rdCode;
  logic         rdHit;

  // carries the four codes to the selector and its choice back
  bzc_sel_if selBus ();

  // read decode: code field of the addressed register, nothing for unmapped
  always_comb begin
    rdCode = CODE_ZERO;
    rdHit  = 1'b1;
    case (regAddr)
      ADDR_BRIGHT_MAX: rdCode = regQ.brightMax;
      ADDR_BRIGHT_DIM: rdCode = regQ.brightDim;
      ADDR_OFFICE_MAX: rdCode = regQ.officeMax;
      ADDR_OFFICE_DIM: rdCode = regQ.officeDim;
      default:         rdHit  = 1'b0;
    endcase
  end

  // register writes and registered read data
  always_comb begin
    regD = regQ;
    if (regWrEn) begin
      case (regAddr)
        ADDR_BRIGHT_MAX: regD.brightMax = regWrData[CODE_MSB:0];
        ADDR_BRIGHT_DIM: regD.brightDim = regWrData[CODE_MSB:0];
        ADDR_OFFICE_MAX: regD.officeMax = regWrData[CODE_MSB:0];
        ADDR_OFFICE_DIM: regD.officeDim = regWrData[CODE_MSB:0];
        default:         regD = regQ; // unmapped writes are dropped
      endcase
    end
    // a read and a write at one edge: the read gets the old code
    if (regRdEn) begin
      regD.rdData = rdHit ? {RSVD_VAL, rdCode} : RD_IDLE; // reserved bit 7 reads zero
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      regQ <= REGS_RESET;
    end else begin
      regQ <= regD;
    end
  end

  // hand the stored codes to the selector
  assign selBus.brightMax = regQ.brightMax;
  assign selBus.brightDim = regQ.brightDim;
  assign selBus.officeMax = regQ.officeMax;
  assign selBus.officeDim = regQ.officeDim;

  bzc_code_select uSelect (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .zoneSel    (zoneSel),
    .dimTimeout (dimTimeout),
    .dimEnable  (dimEnable),
    .codes      (selBus)
  );

  // outputs, all from flops
  assign regRdData   = regQ.rdData;
  assign currentCode = selBus.sel.code;
  assign dimActive   = (selBus.sel.mode == BZC_DIM);
  assign zeroCurrent = selBus.sel.zero;
  assign fullScale   = selBus.sel.full;

  // write checks: only bits 6..0 of the written byte are kept
  // bit 7 is dropped at the write, so the code field alone is compared
  a_wr_bright_max: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_BRIGHT_MAX) |=> (regQ.brightMax == $past(regWrData[CODE_MSB:0])))
    else $error("bright max write lost");
  a_wr_bright_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_BRIGHT_DIM) |=> (regQ.brightDim == $past(regWrData[CODE_MSB:0])))
    else $error("bright dim write lost");
  a_wr_office_max: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_OFFICE_MAX) |=> (regQ.officeMax == $past(regWrData[CODE_MSB:0])))
    else $error("office max write lost");
  a_wr_office_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_OFFICE_DIM) |=> (regQ.officeDim == $past(regWrData[CODE_MSB:0])))
    else $error("office dim write lost");

  // codes hold without a write to their own address
  // a strobe aimed at any other address must leave them alone
  a_hold_bright_max: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrEn && regAddr == ADDR_BRIGHT_MAX) |=> $stable(regQ.brightMax))
    else $error("bright max changed without a write");
  a_hold_bright_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrEn && regAddr == ADDR_BRIGHT_DIM) |=> $stable(regQ.brightDim))
    else $error("bright dim changed without a write");
  a_hold_office_max: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrEn && regAddr == ADDR_OFFICE_MAX) |=> $stable(regQ.officeMax))
    else $error("office max changed without a write");
  a_hold_office_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrEn && regAddr == ADDR_OFFICE_DIM) |=> $stable(regQ.officeDim))
    else $error("office dim changed without a write");

  // write then read back through the port
  // the read sees the code written one edge earlier
  a_rd_back: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_BRIGHT_MAX) ##1 (regRdEn && !regWrEn && regAddr == ADDR_BRIGHT_MAX)
    |=> (regRdData == {1'b0, $past(regWrData[CODE_MSB:0], 2)}))
    else $error("bright max read back wrong");
  a_rd_reserved: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(regRdEn) |-> (regRdData[RSVD_BIT] == RSVD_VAL))
    else $error("reserved bit not zero");

  // read path: a mapped read returns the stored code, an unmapped one zero
  // a read and a write at one edge return the code from before the write
  a_rd_bright_max: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRdEn && regAddr == ADDR_BRIGHT_MAX) |=>
    (regRdData == {RSVD_VAL, $past(regQ.brightMax)}))
    else $error("bright max read wrong");
  a_rd_bright_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRdEn && regAddr == ADDR_BRIGHT_DIM) |=>
    (regRdData == {RSVD_VAL, $past(regQ.brightDim)}))
    else $error("bright dim read wrong");
  a_rd_office_max: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRdEn && regAddr == ADDR_OFFICE_MAX) |=>
    (regRdData == {RSVD_VAL, $past(regQ.officeMax)}))
    else $error("office max read wrong");
  a_rd_office_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRdEn && regAddr == ADDR_OFFICE_DIM) |=>
    (regRdData == {RSVD_VAL, $past(regQ.officeDim)}))
    else $error("office dim read wrong");
  a_rd_unmapped: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRdEn && (regAddr < ADDR_BRIGHT_MAX || regAddr > ADDR_OFFICE_DIM)) |=> (regRdData == RD_IDLE))
    else $error("unmapped read not zero");

  // read data stands until the next read strobe
  // the host may take the byte at any edge before its next read
  a_rd_stands: assert property (@(posedge core_clk) disable iff (!rstn)
    !regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");

  // selection checks: code one cycle after the zone and dim inputs
  // the stored code is sampled at the same edge as the zone
  a_sel_bright_max: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_BRIGHT && !dimTimeout && !dimEnable) |=>
    (currentCode == $past(regQ.brightMax)) && !dimActive)
    else $error("bright max not applied");
  a_sel_bright_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_BRIGHT && (dimTimeout || dimEnable)) |=>
    (currentCode == $past(regQ.brightDim)) && dimActive)
    else $error("bright dim not applied");
  a_sel_office_max: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_OFFICE && !dimTimeout && !dimEnable) |=>
    (currentCode == $past(regQ.officeMax)) && !dimActive)
    else $error("office max not applied");
  a_sel_office_dim: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_OFFICE && (dimTimeout || dimEnable)) |=>
    (currentCode == $past(regQ.officeDim)) && dimActive)
    else $error("office dim not applied");
  // foreign zones give nothing from this bank
  a_sel_other: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel != ZONE_BRIGHT && zoneSel != ZONE_OFFICE) |=> zeroCurrent && !dimActive && (currentCode == CODE_ZERO))
    else $error("foreign zone gave current");

  // a write seen by the lit zone reaches the sinks two edges later
  // one edge lands the register, the next one the selector
  a_code_follow: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_BRIGHT_MAX && zoneSel == ZONE_BRIGHT && !dimTimeout && !dimEnable) ##1
    (zoneSel == ZONE_BRIGHT && !dimTimeout && !dimEnable) |=> (currentCode == $past(regWrData[CODE_MSB:0], 2)))
    else $error("written bright max not applied");

  // dac end points
  // zero and full flags must match the code the sinks see
  a_code_ends: assert property (@(posedge core_clk) disable iff (!rstn)
    (zeroCurrent == (currentCode == CODE_ZERO)) && (fullScale == (currentCode == CODE_FULL)))
    else $error("end point flags wrong");

  // dim codes hold while the dim condition lasts
  // a missed dim would flash the panel back to its maximum code
  a_dim_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_BRIGHT && dimEnable && !regWrEn) [*3] |=> (currentCode == regQ.brightDim))
    else $error("dim code not held");
  a_dim_hold_office: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_OFFICE && dimTimeout && !regWrEn) [*3] |=> (currentCode == regQ.officeDim))
    else $error("office dim code not held");

  // reset clears every code and parks the selector at zero current
  // no disable clause here: this check watches the reset itself
  a_reset_values: assert property (@(posedge core_clk)
    !rstn |=> (regQ == REGS_RESET) && (currentCode == CODE_ZERO) && zeroCurrent && !fullScale && !dimActive
    && (regRdData == RD_IDLE))
    else $error("reset values wrong");

  // main scenarios
  c_bright_dim: cover property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_BRIGHT && !dimEnable && !dimTimeout) ##1 (zoneSel == ZONE_BRIGHT && dimTimeout));
  c_office_dim: cover property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_OFFICE && dimEnable) ##1 dimActive);
  c_full_scale: cover property (@(posedge core_clk) disable iff (!rstn) fullScale);
  c_zone_swap: cover property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_BRIGHT) ##1 (zoneSel == ZONE_OFFICE));
  c_rd_back: cover property (@(posedge core_clk) disable iff (!rstn)
    (regWrEn && regAddr == ADDR_BRIGHT_MAX) ##1 (regRdEn && regAddr == ADDR_BRIGHT_MAX));
endmodule

// File: pkg/bzc_pkg.sv
// constants and types for the backlight zone current registers
package bzc_pkg;
  localparam int unsigned CODE_W    = 7;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 8;
  // register byte addresses
  localparam logic [7:0]  ADDR_BRIGHT_MAX = 8'h0C;
  localparam logic [7:0]  ADDR_BRIGHT_DIM = 8'h0D;
  localparam logic [7:0]  ADDR_OFFICE_MAX = 8'h0E;
  localparam logic [7:0]  ADDR_OFFICE_DIM = 8'h0F;
  // field layout: code in bits 6..0, bit 7 reserved and read as zero
  localparam int unsigned CODE_MSB  = 6;
  localparam int unsigned RSVD_BIT  = 7;
  localparam logic        RSVD_VAL  = 1'h0;
  // code values
  localparam logic [6:0]  CODE_RESET = 7'h00;
  localparam logic [6:0]  CODE_ZERO  = 7'h00;
  localparam logic [6:0]  CODE_FULL  = 7'h7F;
  localparam logic [7:0]  RD_IDLE    = 8'h00;
  // active ambient zone encoding
  localparam logic [1:0]  ZONE_OTHER  = 2'h0;
  localparam logic [1:0]  ZONE_BRIGHT = 2'h1;
  localparam logic [1:0]  ZONE_OFFICE = 2'h2;

  typedef enum logic [2:0] {
    BZC_OFF = 3'b001,
    BZC_MAX = 3'b010,
    BZC_DIM = 3'b100
  } bzc_mode_type;

  typedef struct packed {
    logic [6:0] brightMax;
    logic [6:0] brightDim;
    logic [6:0] officeMax;
    logic [6:0] officeDim;
    logic [7:0] rdData;
  } bzc_regs_type;

  typedef struct packed {
    bzc_mode_type mode;
    logic [6:0]   code;
    logic         zero;
    logic         full;
  } bzc_sel_type;

  localparam bzc_regs_type REGS_RESET = '{brightMax: CODE_RESET, brightDim: CODE_RESET,
                                          officeMax: CODE_RESET, officeDim: CODE_RESET,
                                          rdData: RD_IDLE};
  localparam bzc_sel_type  SEL_RESET  = '{mode: BZC_OFF, code: CODE_ZERO, zero: 1'b1, full: 1'b0};
endpackage

// File: pkg/bzc_sel_if.sv
// codes from the register bank to the selector and the chosen code back
`timescale 1ns/1ps
interface bzc_sel_if;
  import bzc_pkg::*;
  logic [6:0]   brightMax;
  logic [6:0]   brightDim;
  logic [6:0]   officeMax;
  logic [6:0]   officeDim;
  bzc_sel_type  sel;

  modport regs (output brightMax, output brightDim, output officeMax, output officeDim, input sel);
  modport pick (input brightMax, input brightDim, input officeMax, input officeDim, output sel);
endinterface

// File: rtl/bzc_code_select.sv
// picks the backlight code from the active zone and the dim condition
`timescale 1ns/1ps
module bzc_code_select
  import bzc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] zoneSel,
  input  wire logic       dimTimeout,
  input  wire logic       dimEnable,
  bzc_sel_if.pick         codes
);
  bzc_sel_type selQ;
  bzc_sel_type selD;
  logic        dimmed;

  // dim condition: timer expiry or the enable flag
  assign dimmed = dimTimeout | dimEnable;

  // next mode and code
  always_comb begin
    selD = selQ;
    case (zoneSel)
      ZONE_BRIGHT: begin
        selD.mode = dimmed ? BZC_DIM : BZC_MAX;
        selD.code = dimmed ? codes.brightDim : codes.brightMax;
      end
      ZONE_OFFICE: begin
        selD.mode = dimmed ? BZC_DIM : BZC_MAX;
        selD.code = dimmed ? codes.officeDim : codes.officeMax;
      end
      default: begin
        selD.mode = BZC_OFF; // zones outside this bank give no current here
        selD.code = CODE_ZERO;
      end
    endcase
    // code passes straight to the dac: all zeros is off, all ones is full scale
    selD.zero = (selD.code == CODE_ZERO);
    selD.full = (selD.code == CODE_FULL);
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      selQ <= SEL_RESET;
    end else begin
      selQ <= selD;
    end
  end

  assign codes.sel = selQ;

  a_mode_onehot: assert property (@(posedge core_clk) disable iff (!rstn)
    $onehot(selQ.mode)) else $error("mode not one-hot");
  a_zone_off: assert property (@(posedge core_clk) disable iff (!rstn)
    (zoneSel == ZONE_OTHER) |=> (selQ.mode == BZC_OFF) && (selQ.code == CODE_ZERO))
    else $error("foreign zone did not force zero code");
endmodule

// File: dv/bzc_host_model.sv
// host model driving the byte-wide register port of the zone current bank
`timescale 1ns/1ps
module bzc_host_model
  import bzc_pkg::*;
(
  input  wire logic              core_clk,
  output logic      [ADDR_W-1:0] regAddr,
  output logic                   regWrEn,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regRdEn,
  input  wire logic [DATA_W-1:0] regRdData
);
  // idle port: strobes low, address and data scrambled
  initial begin
    regAddr   = 8'hA5;
    regWrEn   = 1'b0;
    regWrData = 8'h5A;
    regRdEn   = 1'b0;
  end

  // one write strobe; lines scrambled after the taking edge
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(posedge core_clk);
    #1;
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask

  // one read strobe; registered data is taken once the read edge has landed
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask

  // write and read of one address on back-to-back edges
  task automatic writeRead(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    #1;
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(posedge core_clk);
    #1;
    regWrEn   = 1'b0;
    regWrData = ~d;
    regRdEn   = 1'b1;
    @(posedge core_clk);
    #1;
    regRdEn   = 1'b0;
    regAddr   = ~a;
    q         = regRdData;
  endtask
endmodule

// File: dv/backlight_zone_current_regs_tb.sv
// self-checking bench for the zone current registers and code selection
`timescale 1ns/1ps
module backlight_zone_current_regs_tb;
  import bzc_pkg::*;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [1:0] zoneSel = 2'h0;
  logic       dimTimeout = 1'b0;
  logic       dimEnable = 1'b0;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic [6:0] currentCode;
  logic       dimActive;
  logic       zeroCurrent;
  logic       fullScale;
  logic [6:0] regs [4];
  logic [7:0] rd;
  logic [7:0] wd;
  logic [7:0] ua;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         seed = 43;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  bzc_zone_regs bzc_zone_regs_inst (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .zoneSel(zoneSel), .dimTimeout(dimTimeout),
    .dimEnable(dimEnable), .currentCode(currentCode), .dimActive(dimActive), .zeroCurrent(zeroCurrent),
    .fullScale(fullScale));
  bzc_host_model bzc_host_model_inst (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // code expected from zone and dim condition
  function automatic logic [6:0] expCode(input logic [1:0] z, input logic dim);
    if (z == ZONE_BRIGHT) return dim ? regs[1] : regs[0];
    if (z == ZONE_OFFICE) return dim ? regs[3] : regs[2];
    return CODE_ZERO;
  endfunction

  // verdict and end of run
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #300000;
    n_errors++;
    print_verdict();
  end

  // reset, then rounds of writes, readback and selection sweeps
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      bzc_host_model_inst.readReg(ADDR_BRIGHT_MAX + 8'(i), rd);
      check(rd, {1'b0, CODE_RESET});
    end
    check(8'(zeroCurrent), 8'h01);
    for (int r = 0; r < 12; r++) begin
      for (int i = 0; i < 4; i++) begin
        wd = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : 8'($random(seed));
        bzc_host_model_inst.writeReg(ADDR_BRIGHT_MAX + 8'(i), wd);
        regs[i] = wd[6:0];
      end
      ua = r[0] ? 8'h0B - 8'(r) : 8'h10 + 8'(r);
      bzc_host_model_inst.writeReg(ua, 8'($random(seed)));
      for (int i = 0; i < 4; i++) begin
        bzc_host_model_inst.readReg(ADDR_BRIGHT_MAX + 8'(i), rd);
        check(rd, {1'b0, regs[i]});
      end
      bzc_host_model_inst.readReg(ua, rd);
      check(rd, RD_IDLE);
      for (int s = 0; s < 16; s++) begin
        zoneSel = 2'(s >> 2);
        dimTimeout = s[0];
        dimEnable = s[1];
        @(posedge core_clk);
        #1;
        check(8'(currentCode), 8'(expCode(zoneSel, s[0] | s[1])));
        check(8'(dimActive), 8'((s[1:0] != 0) && (zoneSel == ZONE_BRIGHT || zoneSel == ZONE_OFFICE)));
        check(8'(zeroCurrent), 8'(expCode(zoneSel, s[0] | s[1]) == CODE_ZERO));
        check(8'(fullScale), 8'(expCode(zoneSel, s[0] | s[1]) == CODE_FULL));
      end
      // dim condition held for several edges, bright zone then office zone
      for (int h = 0; h < 8; h++) begin
        zoneSel = (h < 4) ? ZONE_BRIGHT : ZONE_OFFICE;
        dimTimeout = (h < 4) ? 1'($random(seed)) : 1'b1;
        dimEnable = (h < 4);
        @(posedge core_clk);
        #1;
        check(8'(currentCode), 8'(expCode(zoneSel, 1'b1)));
        check(8'(dimActive), 8'h01);
      end
      // back-to-back write and read while the bright zone is lit and undimmed
      zoneSel = ZONE_BRIGHT;
      dimTimeout = 1'b0;
      dimEnable = 1'b0;
      wd = 8'($random(seed));
      bzc_host_model_inst.writeRead(ADDR_BRIGHT_MAX, wd, rd);
      regs[0] = wd[6:0];
      check(rd, {1'b0, regs[0]});
      check(8'(currentCode), 8'(regs[0]));
    end
    // reset again in mid-run: every code returns to zero
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      regs[i] = CODE_RESET;
      bzc_host_model_inst.readReg(ADDR_BRIGHT_MAX + 8'(i), rd);
      check(rd, {1'b0, CODE_RESET});
    end
    check(8'(zeroCurrent), 8'h01);
    print_verdict();
  end
endmodule
